/* design/fpe_defs.vh */
`ifndef FPE_DEFS_VH
`define FPE_DEFS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define FPE_ADDR_CTRL 8'h00
`define FPE_ADDR_KEY 8'h04
`define FPE_ADDR_TGT_LOW 8'h08
`define FPE_ADDR_TGT_UPPER 8'h0C
`define FPE_ADDR_SRC_LOW 8'h10
`define FPE_ADDR_SRC_HIGH 8'h14
`define FPE_ADDR_FIFO_FILL 8'h18
// ----------------------------------------
// control field positions
// ----------------------------------------
`define FPE_BIT_START 15
`define FPE_BIT_ENABLE 14
`define FPE_BIT_SEQERR 13
`define FPE_BIT_SIDL 12
`define FPE_BIT_FORMAT 9
`define FPE_BIT_UNDERRUN 8
`define FPE_CTRL_WMASK 16'h520F
`define FPE_CTRL_RESET 16'h0000
// ----------------------------------------
// unlock keys and operation codes
// ----------------------------------------
`define FPE_KEY_FIRST 8'h55
`define FPE_KEY_SECOND 8'hAA
`define FPE_OP_DWORD 4'h1
`define FPE_OP_ROW 4'h2
`define FPE_OP_PAGE 4'h3
// ----------------------------------------
// geometry and timing
// ----------------------------------------
`define FPE_ROW_WORDS 7'd64
`define FPE_ROW_BYTES 24'd192
`define FPE_PAGE_BYTES 24'd1536
`define FPE_FIFO_DEPTH 8
`define FPE_FIFO_AW 3
`define FPE_FETCH_TIMEOUT 8'hFF
`endif

/* design/fpe_fifo.v */
// ----------------------------------------
// word fifo, flip-flop storage
// ----------------------------------------
module fpe_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire flush,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] fill_level
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] rptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = (count_reg != DEPTH);
    assign out_valid = (count_reg != 0);
    assign out_data = mem_reg[rptr_reg];
    assign fill_level = count_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge hclk) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (flush) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

/* design/fpe_flash_ctrl.v */
// Notes on behaviour
// - seven registers: control, write-only key, two target, two source address and read-only fifo fill.
// - control selects erase or program operation and holds the start trigger.
// - key is write-only; 0x55 then 0xAA consecutively unlocks one operation.
// - target registers join into a 24-bit address of word or page.
// - upper register gives address bits 23..16, lower gives bits 15..0.
// - the source low register holds the 16-bit RAM address of the data to program; source high is stored but not used.
// - a row underrun ends row programming and leaves the sequence error set.
// - double-word program writes two adjacent words on a 4-address (two-word) boundary.
// - erase a 1536-byte page; program a 192-byte row or two words.
// - the processor is stalled while an operation is in progress.
// - row programming fetches source data from RAM at the source address.
`include "fpe_defs.vh"
module fpe_flash_ctrl (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // processor stall
    output wire cpu_stall,
    // ram fetch master
    output reg ram_req,
    output reg [15:0] ram_addr,
    input wire ram_ack,
    input wire [23:0] ram_rdata,
    // flash array
    output reg flash_erase,
    output reg flash_prog,
    output reg [23:0] flash_addr,
    output reg [23:0] flash_wdata,
    output wire flash_compressed,
    output wire flash_standby_in_idle,
    input wire flash_busy
);
    // ----------------------------------------
    // state codes
    // ----------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_ERASE = 3'd1;
    localparam ST_DWORD = 3'd2;
    localparam ST_ROW = 3'd3;
    localparam ST_WAIT = 3'd4;

    reg [15:0] ctrl_reg;
    reg [15:0] tgt_low_reg;
    reg [7:0] tgt_upper_reg;
    reg [15:0] src_low_reg;
    reg [15:0] src_high_reg;
    reg [1:0] key_state_reg;
    reg [2:0] state_reg;
    reg [6:0] word_cnt_reg;
    reg [7:0] starve_reg;
    reg [1:0] dword_cnt_reg;
    reg wr_pend_reg;
    reg [7:0] addr_q_reg;
    reg busy_seen_reg;
    wire [23:0] eff_addr;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [23:0] fifo_out_data;
    wire [3:0] fifo_fill;
    wire fifo_pop;
    wire fifo_flush;
    wire valid_op;
    wire [15:0] wr16;
    wire op_done;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function is_known_op;
        input [3:0] op;
        begin
            is_known_op = (op == `FPE_OP_DWORD) || (op == `FPE_OP_ROW) ||
                (op == `FPE_OP_PAGE);
        end
    endfunction

    function [23:0] align_down;
        input [23:0] a;
        input [23:0] size;
        begin
            align_down = a - (a % size);
        end
    endfunction

    assign eff_addr = {tgt_upper_reg, tgt_low_reg};
    assign wr16 = hwdata[15:0];
    assign valid_op = is_known_op(ctrl_reg[3:0]);
    assign flash_compressed = ctrl_reg[`FPE_BIT_FORMAT];
    assign flash_standby_in_idle = ctrl_reg[`FPE_BIT_SIDL];

    // ----------------------------------------
    // bus slave: zero wait states for registers, except writes while busy
    // ----------------------------------------
    // writes to any register stall while busy so software cannot retarget a running operation
    assign cpu_stall = (state_reg != ST_IDLE);
    assign hreadyout = !(wr_pend_reg && cpu_stall);
    assign hresp = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_q_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            addr_q_reg <= haddr;
        end
    end

    wire wr_now = wr_pend_reg && !cpu_stall;
    wire start_req = wr_now && (addr_q_reg == `FPE_ADDR_CTRL) && wr16[`FPE_BIT_START];
    wire start_ok = start_req && ctrl_reg[`FPE_BIT_ENABLE] && (key_state_reg == 2'd2);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (haddr == `FPE_ADDR_CTRL) begin
                hrdata <= {16'h0000, ctrl_reg};
            end else if (haddr == `FPE_ADDR_TGT_LOW) begin
                hrdata <= {16'h0000, tgt_low_reg};
            end else if (haddr == `FPE_ADDR_TGT_UPPER) begin
                hrdata <= {24'h000000, tgt_upper_reg};
            end else if (haddr == `FPE_ADDR_SRC_LOW) begin
                hrdata <= {16'h0000, src_low_reg};
            end else if (haddr == `FPE_ADDR_SRC_HIGH) begin
                hrdata <= {16'h0000, src_high_reg};
            end else if (haddr == `FPE_ADDR_FIFO_FILL) begin
                hrdata <= {28'h0000000, fifo_fill};
            end else begin
                // key register is write-only and reads zero
                hrdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // registers and unlock sequence
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tgt_low_reg <= 16'h0000;
            tgt_upper_reg <= 8'h00;
            src_low_reg <= 16'h0000;
            src_high_reg <= 16'h0000;
            key_state_reg <= 2'd0;
        end else if (wr_now) begin
            if (addr_q_reg == `FPE_ADDR_KEY) begin
                // any other write breaks the pair, so the two must be consecutive
                if (hwdata[7:0] == `FPE_KEY_FIRST) begin
                    key_state_reg <= 2'd1;
                end else if (hwdata[7:0] == `FPE_KEY_SECOND && key_state_reg == 2'd1) begin
                    key_state_reg <= 2'd2;
                end else begin
                    key_state_reg <= 2'd0;
                end
            end else if (addr_q_reg == `FPE_ADDR_CTRL) begin
                key_state_reg <= 2'd0;
            end else begin
                key_state_reg <= 2'd0;
                if (addr_q_reg == `FPE_ADDR_TGT_LOW) begin
                    tgt_low_reg <= wr16;
                end else if (addr_q_reg == `FPE_ADDR_TGT_UPPER) begin
                    tgt_upper_reg <= hwdata[7:0];
                end else if (addr_q_reg == `FPE_ADDR_SRC_LOW) begin
                    src_low_reg <= wr16;
                end else if (addr_q_reg == `FPE_ADDR_SRC_HIGH) begin
                    src_high_reg <= wr16;
                end
            end
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `FPE_CTRL_RESET;
        end else begin
            if (wr_now && addr_q_reg == `FPE_ADDR_CTRL) begin
                ctrl_reg <= (ctrl_reg & ~`FPE_CTRL_WMASK) | (wr16 & `FPE_CTRL_WMASK);
                if (start_req && !ctrl_reg[`FPE_BIT_ENABLE]) begin
                    ctrl_reg[`FPE_BIT_START] <= 1'b0;
                end else if (start_req && !start_ok) begin
                    ctrl_reg[`FPE_BIT_SEQERR] <= 1'b1;
                end else if (start_ok && valid_op) begin
                    ctrl_reg[`FPE_BIT_START] <= 1'b1;
                    ctrl_reg[`FPE_BIT_SEQERR] <= 1'b1;
                    ctrl_reg[`FPE_BIT_UNDERRUN] <= 1'b0;
                end
            end
            if (op_done) begin
                ctrl_reg[`FPE_BIT_START] <= 1'b0;
                ctrl_reg[`FPE_BIT_SEQERR] <= 1'b0;
            end
            if (state_reg == ST_ROW && starve_reg == `FPE_FETCH_TIMEOUT) begin
                ctrl_reg[`FPE_BIT_START] <= 1'b0;
                ctrl_reg[`FPE_BIT_UNDERRUN] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // operation sequencer
    // ----------------------------------------
    // sequence error is held during the run and cleared only on clean finish
    assign op_done = (state_reg == ST_WAIT) && busy_seen_reg && !flash_busy;
    // busy rises a cycle after the pulse, so the pulse itself also blocks the next pop
    assign fifo_pop = (state_reg == ST_ROW || state_reg == ST_DWORD) &&
        fifo_out_valid && !flash_busy && !flash_prog;
    assign fifo_flush = (state_reg == ST_IDLE);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            word_cnt_reg <= 7'd0;
            starve_reg <= 8'h00;
            dword_cnt_reg <= 2'd0;
            busy_seen_reg <= 1'b0;
            ram_req <= 1'b0;
            ram_addr <= 16'h0000;
            flash_erase <= 1'b0;
            flash_prog <= 1'b0;
            flash_addr <= 24'h000000;
            flash_wdata <= 24'h000000;
        end else begin
            flash_erase <= 1'b0;
            flash_prog <= 1'b0;
            case (state_reg)
            ST_IDLE: begin
                word_cnt_reg <= 7'd0;
                dword_cnt_reg <= 2'd0;
                starve_reg <= 8'h00;
                busy_seen_reg <= 1'b0;
                ram_addr <= src_low_reg;
                if (start_ok && valid_op && ctrl_reg[`FPE_BIT_ENABLE]) begin
                    if (ctrl_reg[3:0] == `FPE_OP_PAGE) begin
                        state_reg <= ST_ERASE;
                        flash_addr <= align_down(eff_addr, `FPE_PAGE_BYTES);
                    end else if (ctrl_reg[3:0] == `FPE_OP_ROW) begin
                        state_reg <= ST_ROW;
                        flash_addr <= align_down(eff_addr, `FPE_ROW_BYTES);
                    end else begin
                        state_reg <= ST_DWORD;
                        flash_addr <= {eff_addr[23:2], 2'b00};
                    end
                end
            end
            ST_ERASE: begin
                flash_erase <= 1'b1;
                state_reg <= ST_WAIT;
            end
            ST_DWORD, ST_ROW: begin
                // two words or a row of 64, both fetched from ram through the fifo
                ram_req <= fifo_in_ready && !(ram_req && ram_ack);
                if (ram_req && ram_ack) begin
                    ram_addr <= ram_addr + 16'h0002;
                end
                if (fifo_pop) begin
                    starve_reg <= 8'h00;
                    flash_prog <= 1'b1;
                    flash_wdata <= fifo_out_data;
                    if (word_cnt_reg != 7'd0) begin
                        flash_addr <= flash_addr + 24'h000002;
                    end
                    word_cnt_reg <= word_cnt_reg + 7'd1;
                    if ((state_reg == ST_DWORD && word_cnt_reg == 7'd1) ||
                        word_cnt_reg == `FPE_ROW_WORDS - 7'd1) begin
                        state_reg <= ST_WAIT;
                        ram_req <= 1'b0;
                    end
                end else if (state_reg == ST_ROW) begin
                    if (starve_reg == `FPE_FETCH_TIMEOUT) begin
                        state_reg <= ST_IDLE;
                        ram_req <= 1'b0;
                    end else begin
                        starve_reg <= starve_reg + 8'h01;
                    end
                end
            end
            ST_WAIT: begin
                ram_req <= 1'b0;
                if (flash_busy) begin
                    busy_seen_reg <= 1'b1;
                end
                if (op_done) begin
                    state_reg <= ST_IDLE;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
            endcase
        end
    end

    // ----------------------------------------
    // source word buffer
    // ----------------------------------------
    fpe_fifo #(
        .WIDTH(24),
        .DEPTH(`FPE_FIFO_DEPTH),
        .AW(`FPE_FIFO_AW)
    ) u_fpe_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .flush(fifo_flush),
        .in_valid(ram_req && ram_ack),
        .in_ready(fifo_in_ready),
        .in_data(ram_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .fill_level(fifo_fill)
    );
endmodule

/* sim/fpe_flash_ctrl_assertions.sv */
`include "fpe_defs.vh"
module fpe_flash_ctrl_chk (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    // far side
    input wire cpu_stall,
    input wire ram_req,
    input wire [15:0] ram_addr,
    input wire ram_ack,
    input wire flash_erase,
    input wire flash_prog,
    input wire [23:0] flash_addr,
    input wire flash_compressed,
    input wire flash_standby_in_idle
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ----
    // shadow of bus writes, taken as each data phase ends
    // ----
    reg wr_reg;
    reg [7:0] wa_reg;
    reg [23:0] tgt_reg;
    reg [1:0] lvl_reg;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= 1'b0;
            wa_reg <= 8'h00;
            tgt_reg <= 24'h000000;
            lvl_reg <= 2'b00;
        end else if (hready) begin
            wr_reg <= hsel && htrans[1] && hwrite;
            wa_reg <= haddr;
            if (wr_reg && wa_reg == `FPE_ADDR_TGT_LOW) tgt_reg[15:0] <= hwdata[15:0];
            if (wr_reg && wa_reg == `FPE_ADDR_TGT_UPPER) tgt_reg[23:16] <= hwdata[7:0];
            if (wr_reg && wa_reg == `FPE_ADDR_CTRL) lvl_reg <= {hwdata[12], hwdata[9]};
        end
    end
    // ----
    // properties
    // ----
    a_resp_always_okay: assert property (!hresp)
        else $error("slave gave an error response");
    a_erase_one_cycle: assert property (flash_erase |=> !flash_erase)
        else $error("erase pulse longer than one cycle");
    a_prog_one_cycle: assert property (flash_prog |=> !flash_prog)
        else $error("program pulse longer than one cycle");
    a_erase_while_stalled: assert property (flash_erase |-> cpu_stall)
        else $error("erase issued without processor stall");
    a_prog_stall_holds: assert property (flash_prog |-> cpu_stall ##1 cpu_stall)
        else $error("stall dropped around a program pulse");
    a_wait_only_busy: assert property (!hreadyout |-> cpu_stall)
        else $error("bus wait state while idle");
    a_fetch_addr_held: assert property ((ram_req && !ram_ack) ##1 ram_req |-> $stable(ram_addr))
        else $error("fetch address moved before acknowledge");
    a_idle_no_fetch: assert property (!cpu_stall |-> !ram_req)
        else $error("ram fetch outside an operation");
    a_erase_target_addr: assert property (flash_erase |->
        flash_addr == tgt_reg - (tgt_reg % `FPE_PAGE_BYTES))
        else $error("erase address differs from target registers");
    a_format_levels: assert property (flash_compressed == lvl_reg[0] && flash_standby_in_idle == lvl_reg[1])
        else $error("format or standby level differs from control");
endmodule
bind fpe_flash_ctrl fpe_flash_ctrl_chk u_fpe_flash_ctrl_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_stall(cpu_stall), .ram_req(ram_req), .ram_addr(ram_addr), .ram_ack(ram_ack),
    .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_addr(flash_addr),
    .flash_compressed(flash_compressed), .flash_standby_in_idle(flash_standby_in_idle)
);

/* sim/fpe_flash_ram_model.sv */
module fpe_flash_ram_model #(
    parameter int BUSY_CYCLES = 6
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // flash array
    input wire flash_erase,
    input wire flash_prog,
    input wire [23:0] flash_addr,
    input wire [23:0] flash_wdata,
    output wire flash_busy,
    // data ram
    input wire ram_req,
    input wire [15:0] ram_addr,
    output logic ram_ack,
    output logic [23:0] ram_rdata,
    // bench control and tallies
    input wire ram_hold,
    input wire clr,
    output int erase_cnt,
    output int prog_cnt,
    output logic [23:0] last_erase,
    output logic [23:0] first_addr,
    output logic [23:0] first_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int busy_left;
    logic slow;
    wire go;
    assign flash_busy = busy_left > 0;
    // ack only every other try, so the fifo also meets a slow source
    assign go = ram_req && !ram_ack && !ram_hold && slow;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_left <= 0;
            slow <= 1'b0;
            ram_ack <= 1'b0;
            ram_rdata <= 24'h000000;
            erase_cnt <= 0;
            prog_cnt <= 0;
        end else begin
            if (flash_erase || flash_prog) busy_left <= BUSY_CYCLES;
            else if (busy_left > 0) busy_left <= busy_left - 1;
            slow <= slow ^ (ram_req && !ram_ack && !ram_hold);
            ram_ack <= go;
            // between acks the data lines toggle between the last word and its inverse
            ram_rdata <= go ? {8'h5A, ram_addr} : ~ram_rdata;
            if (clr) begin
                erase_cnt <= 0;
                prog_cnt <= 0;
            end else begin
                if (flash_erase) erase_cnt <= erase_cnt + 1;
                if (flash_erase) last_erase <= flash_addr;
                if (flash_prog) prog_cnt <= prog_cnt + 1;
                if (flash_prog && prog_cnt == 0) first_addr <= flash_addr;
                if (flash_prog && prog_cnt == 0) first_data <= flash_wdata;
            end
        end
    end
endmodule

/* sim/tb_top.sv */
`include "fpe_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, ram_hold, clr;
    logic saw_stall = 1'b0;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, rd;
    wire hreadyout, hresp, cpu_stall, ram_req, ram_ack, flash_erase, flash_prog, flash_busy;
    wire flash_compressed, flash_standby_in_idle;
    wire [31:0] hrdata;
    wire [15:0] ram_addr;
    wire [23:0] ram_rdata, flash_addr, flash_wdata, last_erase, first_addr, first_data;
    int erase_cnt, prog_cnt, total_checks = 0, miscompares = 0, cycles = 0;
    logic [7:0] adr [4] = '{`FPE_ADDR_TGT_LOW, `FPE_ADDR_TGT_UPPER, `FPE_ADDR_SRC_LOW,
        `FPE_ADDR_SRC_HIGH};
    logic [31:0] msk [4] = '{32'h0000FFFF, 32'h000000FF, 32'h0000FFFF, 32'h0000FFFF};
    fpe_flash_ctrl u_fpe_flash_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_stall(cpu_stall),
        .ram_req(ram_req), .ram_addr(ram_addr), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
        .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_compressed(flash_compressed),
        .flash_standby_in_idle(flash_standby_in_idle), .flash_busy(flash_busy)
    );
    fpe_flash_ram_model u_fpe_flash_ram_model (
        .hclk(hclk), .hresetn(hresetn), .flash_erase(flash_erase), .flash_prog(flash_prog),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_busy(flash_busy),
        .ram_req(ram_req), .ram_addr(ram_addr), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
        .ram_hold(ram_hold), .clr(clr), .erase_cnt(erase_cnt), .prog_cnt(prog_cnt),
        .last_erase(last_erase), .first_addr(first_addr), .first_data(first_data)
    );
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (clr) saw_stall <= 1'b0;
        else if (cpu_stall === 1'b1) saw_stall <= 1'b1;
        cycles <= cycles + 1;
        // ceiling well above the longest row program plus underrun wait
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    // ----
    // bus cycles and checks
    // ----
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic note(input string name);
        $display("test %s finished", name);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
    endtask
    task automatic launch(input logic [3:0] op);
        xfer(1, `FPE_ADDR_CTRL, {16'h0000, 4'h4, 8'h00, op});
        xfer(1, `FPE_ADDR_KEY, {24'h000000, `FPE_KEY_FIRST});
        xfer(1, `FPE_ADDR_KEY, {24'h000000, `FPE_KEY_SECOND});
        xfer(1, `FPE_ADDR_CTRL, {16'h0000, 4'hC, 8'h00, op});
    endtask
    task automatic wait_idle;
        rd = 32'h00008000;
        while (rd[15] === 1'b1) xfer(0, `FPE_ADDR_CTRL, 32'h00000000);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hwrite = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        ram_hold = 1'b0;
        clr = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(0, `FPE_ADDR_CTRL, 32'h00000000);
        chk(rd, {16'h0000, `FPE_CTRL_RESET});
        xfer(1, `FPE_ADDR_KEY, {24'h000000, `FPE_KEY_FIRST});
        xfer(0, `FPE_ADDR_KEY, 32'h00000000);
        chk(rd, 32'h00000000);
        xfer(1, 8'h1C, 32'hFFFFFFFF);
        xfer(0, 8'h1C, 32'h00000000);
        chk(rd, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            xfer(1, adr[i], 32'hFFFF5AC3 ^ i);
            xfer(0, adr[i], 32'h00000000);
            chk(rd, (32'hFFFF5AC3 ^ i) & msk[i]);
        end
        xfer(1, `FPE_ADDR_CTRL, 32'h00007E0F);
        xfer(0, `FPE_ADDR_CTRL, 32'h00000000);
        chk(rd, {16'h0000, `FPE_CTRL_WMASK});
        xfer(1, `FPE_ADDR_CTRL, 32'h00000000);
        note("registers");
        xfer(1, `FPE_ADDR_CTRL, 32'h00008003);
        xfer(0, `FPE_ADDR_CTRL, 32'h00000000);
        chk(rd, 32'h00000003);
        xfer(1, `FPE_ADDR_CTRL, 32'h00004003);
        xfer(1, `FPE_ADDR_CTRL, 32'h0000C003);
        xfer(0, `FPE_ADDR_CTRL, 32'h00000000);
        chk(rd & 32'h0000E000, 32'h00006000);
        xfer(1, `FPE_ADDR_KEY, {24'h000000, `FPE_KEY_FIRST});
        xfer(1, `FPE_ADDR_TGT_LOW, 32'h00000700);
        xfer(1, `FPE_ADDR_KEY, {24'h000000, `FPE_KEY_SECOND});
        xfer(1, `FPE_ADDR_CTRL, 32'h0000C003);
        xfer(0, `FPE_ADDR_CTRL, 32'h00000000);
        chk(rd & 32'h0000A000, 32'h00002000);
        chk(32'(erase_cnt + prog_cnt), 32'h00000000);
        note("refused starts");
        xfer(1, `FPE_ADDR_TGT_UPPER, 32'h00000003);
        launch(`FPE_OP_PAGE);
        wait_idle();
        chk(rd, 32'h00004003);
        chk(32'(erase_cnt), 32'h00000001);
        chk({8'h00, last_erase}, 32'h00030600);
        chk({31'h0, saw_stall}, 32'h00000001);
        note("page erase");
        xfer(1, `FPE_ADDR_TGT_UPPER, 32'h00000000);
        xfer(1, `FPE_ADDR_TGT_LOW, 32'h00000008);
        xfer(1, `FPE_ADDR_SRC_LOW, 32'h00000040);
        launch(`FPE_OP_DWORD);
        wait_idle();
        chk(32'(prog_cnt), 32'h00000002);
        chk({8'h00, first_addr}, 32'h00000008);
        chk({8'h00, first_data}, 32'h005A0040);
        note("double word");
        xfer(1, `FPE_ADDR_SRC_LOW, 32'h00000100);
        launch(`FPE_OP_ROW);
        repeat (150) @(posedge hclk);
        xfer(0, `FPE_ADDR_FIFO_FILL, 32'h00000000);
        chk(32'(rd >= 7 && rd <= 8), 32'h00000001);
        // this write is held off by wait states until the row is done
        xfer(1, `FPE_ADDR_CTRL, 32'h00004202);
        chk(32'(prog_cnt), 32'h00000040);
        chk({8'h00, first_data}, 32'h005A0100);
        xfer(0, `FPE_ADDR_CTRL, 32'h00000000);
        chk(rd, 32'h00004202);
        note("row program");
        ram_hold <= 1'b1;
        launch(`FPE_OP_ROW);
        wait_idle();
        chk(rd & 32'h0000A100, 32'h00002100);
        chk(32'(prog_cnt), 32'h00000000);
        ram_hold <= 1'b0;
        note("underrun");
        for (int op = 0; op < 16; op++) begin
            if (op == 0 || op > 3) begin
                launch(4'(op));
                repeat (20) @(posedge hclk);
                chk(32'(erase_cnt + prog_cnt), 32'h00000000);
            end
        end
        chk({31'h0, saw_stall}, 32'h00000000);
        note("undefined codes");
        test_done();
    end
endmodule
